// ===== hsc_holdover_switch.v
// Purpose: Holdover entry and exit, reference choice and tuning tracking control with APB registers.
// Assumes: All inputs except arst_n synchronous to clk; pd_clk_valid is a one-cycle pulse per valid phase detector clock.
// Notes:   Tune voltage arrives as a 10-bit code; rail thresholds compare its top six bits.
`timescale 1ns/1ns
`default_nettype none
`include "hsc_regs.vh"
module hsc_holdover_switch #(
    parameter CODE_W = 10
) (
    // Clock and reset.
    input  wire              clk,
    input  wire              arst_n,
    // APB slave.
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [11:0]       paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    // Loop status and tuning input.
    input  wire              loop_locked,
    input  wire              pd_clk_valid,
    input  wire [CODE_W-1:0] tune_code,
    input  wire [2:0]        int_signal_absent,
    // External signal-absent pins.
    input  wire              ref_select_pin_zero,
    input  wire              ref_select_pin_one,
    input  wire              status_pin_one,
    // Outputs to the clock path.
    output reg  [1:0]        ref_active,
    output reg               holdover_active,
    output reg               pump_float,
    output reg               dyn_delay_allow,
    output reg  [CODE_W-1:0] tune_dac
);
    localparam ST_NORMAL = 2'd0;
    localparam ST_HOLD   = 2'd1;
    localparam ST_EXIT   = 2'd2;

    reg  [7:0]        rate_trip;
    reg  [7:0]        rate_count;
    reg  [7:0]        switch_cfg;
    reg  [5:0]        low_trip;
    reg  [13:0]       exit_count;
    reg  [CODE_W-1:0] manual_tune_value;
    reg               track_enable;
    reg               force_hold;
    reg               manual_tune_enable;
    reg  [1:0]        manual_reference_choice;
    reg  [CODE_W-1:0] track_code;
    reg  [1:0]        state;
    reg  [13:0]       valid_count;
    reg  [3:0]        switch_timer;
    reg               lock_prev;
    reg  [4:0]        mult_shift;
    reg  [21:0]       rate_period;
    reg  [1:0]        next_ref;
    reg  [31:0]       next_rdata;
    reg               rail_trip;
    reg               ref_absent;
    reg  [2:0]        absent_now;
    reg               rate_reload;
    wire              track_tick;
    wire              lock_drop;
    wire              switch_event;
    wire              acc;
    wire [9:0]        reg_idx;
    wire              idx_ok;

    // Word index taken from the byte address.
    assign acc     = psel & penable;
    assign reg_idx = paddr[11:2];
    assign idx_ok  = (paddr[1:0] == 2'b00);

    // Multiplier decode and update period.
    always @* begin
        case (rate_trip[7:6])
            2'd0:    mult_shift = `HSC_MULT_SHIFT0;
            2'd1:    mult_shift = `HSC_MULT_SHIFT1;
            2'd2:    mult_shift = `HSC_MULT_SHIFT2;
            default: mult_shift = `HSC_MULT_SHIFT3;
        endcase
        rate_period = {14'h0000, rate_count} << mult_shift;
    end

    // Reload request one cycle after a rate write, so the counter takes the new period, not the old one.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_reload <= 1'b0;
        end else begin
            rate_reload <= acc && pwrite && idx_ok &&
                           ((reg_idx == `HSC_IDX_RATE_TRIP) || (reg_idx == `HSC_IDX_RATE_COUNT));
        end
    end

    // Rate counter reloads on each tracking update and on a write to either rate register.
    hsc_sync_count #(
        .WIDTH      (22)
    ) u_rate (
        .clk        (clk),
        .arst_n     (arst_n),
        .load       (rate_reload),
        .load_value (rate_period),
        .run        (track_enable),
        .expired    (track_tick)
    );

    // Signal-absent source selection and rail detection.
    always @* begin
        if (switch_cfg[`HSC_CFG_EXT_ABSENT]) begin
            absent_now = {status_pin_one, ref_select_pin_one, ref_select_pin_zero};
        end else begin
            absent_now = int_signal_absent;
        end
        ref_absent = (ref_active == 2'd3) ? 1'b1 : absent_now[ref_active];
        rail_trip  = switch_cfg[`HSC_CFG_RAIL_DET] &&
                     ((tune_code[CODE_W-1:CODE_W-6] >= (6'h3F - rate_trip[5:0])) ||
                      (tune_code[CODE_W-1:CODE_W-6] <= low_trip));
    end

    // Lock drop edge and the combined switch event.
    assign lock_drop    = switch_cfg[`HSC_CFG_LOCK_DROP] & lock_prev & ~loop_locked;
    assign switch_event = lock_drop | rail_trip;

    // Reference choice: forced manual, else first present input other than the active one under a rail trip, else input 2.
    always @* begin
        if (switch_cfg[`HSC_CFG_FORCE_SEL] || manual_tune_enable) begin
            next_ref = (manual_reference_choice == 2'd3) ? 2'd0 : manual_reference_choice;
        end else if (!absent_now[0] && !(rail_trip && ref_active == 2'd0)) begin
            next_ref = 2'd0;
        end else if (!absent_now[1] && !(rail_trip && ref_active == 2'd1)) begin
            next_ref = 2'd1;
        end else begin
            next_ref = 2'd2;
        end
    end

    // Holdover state machine.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state        <= ST_NORMAL;
            valid_count  <= 14'h0000;
            switch_timer <= 4'h0;
            lock_prev    <= 1'b0;
            ref_active   <= 2'd0;
        end else begin
            lock_prev <= loop_locked;
            // Manual mode or override keeps the reference on the manual choice at all times.
            if (switch_cfg[`HSC_CFG_FORCE_SEL] || manual_tune_enable) begin
                ref_active <= next_ref;
            end
            if (switch_timer != 4'h0) begin
                switch_timer <= switch_timer - 4'h1;
            end
            case (state)
                ST_NORMAL: begin
                    if (switch_cfg[`HSC_CFG_HOLD_EN] && (switch_event || force_hold || ref_absent)) begin
                        state        <= ST_HOLD;
                        switch_timer <= `HSC_SWITCH_CYCLES;
                        ref_active   <= next_ref;
                    end
                end
                ST_HOLD: begin
                    valid_count <= 14'h0000;
                    if (!switch_cfg[`HSC_CFG_HOLD_EN]) begin
                        state <= ST_NORMAL;
                    end else if (!force_hold && !rail_trip) begin
                        if (!switch_cfg[`HSC_CFG_EXIT_MODE] && !ref_absent) begin
                            state <= ST_EXIT;
                        end else if (switch_cfg[`HSC_CFG_EXIT_MODE] && loop_locked) begin
                            state <= ST_EXIT;
                        end
                    end
                end
                ST_EXIT: begin
                    if (!switch_cfg[`HSC_CFG_HOLD_EN]) begin
                        state <= ST_NORMAL;
                    end else if (switch_event || force_hold) begin
                        state <= ST_HOLD;
                    end else if (pd_clk_valid) begin
                        if (valid_count >= exit_count) begin
                            state <= ST_NORMAL;
                        end else begin
                            valid_count <= valid_count + 14'h0001;
                        end
                    end
                end
                default: state <= ST_NORMAL;
            endcase
        end
    end

    // Tracked code and outputs.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            track_code      <= `HSC_RST_TRACK_CODE;
            holdover_active <= 1'b0;
            pump_float      <= 1'b0;
            dyn_delay_allow <= 1'b1;
            tune_dac        <= `HSC_RST_TRACK_CODE;
        end else begin
            if (track_tick && loop_locked && state == ST_NORMAL) begin
                track_code <= tune_code;
            end
            holdover_active <= (state != ST_NORMAL);
            pump_float      <= switch_cfg[`HSC_CFG_PUMP_FLOAT] && (switch_timer != 4'h0);
            dyn_delay_allow <= ~switch_cfg[`HSC_CFG_FORCE_SEL];
            if (state != ST_NORMAL && manual_tune_enable) begin
                tune_dac <= manual_tune_value;
            end else if (state != ST_NORMAL) begin
                tune_dac <= track_code;
            end else begin
                tune_dac <= tune_code;
            end
        end
    end

    // Register writes at the access edge.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_trip               <= `HSC_RST_RATE_TRIP;
            rate_count              <= `HSC_RST_RATE_COUNT;
            switch_cfg              <= `HSC_RST_SWITCH_CFG;
            low_trip                <= `HSC_RST_LOW_TRIP;
            exit_count              <= `HSC_RST_EXIT_COUNT;
            manual_tune_value       <= `HSC_RST_MANUAL_TUNE;
            track_enable            <= 1'b0;
            force_hold              <= 1'b0;
            manual_tune_enable      <= 1'b0;
            manual_reference_choice <= 2'd0;
        end else if (acc && pwrite && idx_ok) begin
            case (reg_idx)
                `HSC_IDX_RATE_TRIP:  rate_trip  <= pwdata[7:0];
                `HSC_IDX_RATE_COUNT: rate_count <= pwdata[7:0];
                `HSC_IDX_SWITCH_CFG: switch_cfg <= {1'b0, pwdata[6:0]};
                `HSC_IDX_LOW_TRIP:   low_trip   <= pwdata[5:0];
                `HSC_IDX_EXIT_COUNT: exit_count <= pwdata[13:0];
                `HSC_IDX_TUNE_CTRL: begin
                    manual_tune_value       <= pwdata[CODE_W-1:0];
                    track_enable            <= pwdata[`HSC_TC_TRACK_EN];
                    force_hold              <= pwdata[`HSC_TC_FORCE_HOLD];
                    manual_tune_enable      <= pwdata[`HSC_TC_MAN_EN];
                    manual_reference_choice <= pwdata[`HSC_TC_MAN_SEL_LSB+1:`HSC_TC_MAN_SEL_LSB];
                end
                default: manual_tune_enable <= manual_tune_enable;
            endcase
        end
    end

    // Read mux.
    always @* begin
        case (reg_idx)
            `HSC_IDX_RATE_TRIP:  next_rdata = {24'h000000, rate_trip};
            `HSC_IDX_RATE_COUNT: next_rdata = {24'h000000, rate_count};
            `HSC_IDX_SWITCH_CFG: next_rdata = {24'h000000, switch_cfg};
            `HSC_IDX_LOW_TRIP:   next_rdata = {26'h0000000, low_trip};
            `HSC_IDX_EXIT_COUNT: next_rdata = {18'h00000, exit_count};
            `HSC_IDX_TUNE_CTRL:  next_rdata = {17'h00000, manual_reference_choice, manual_tune_enable,
                                               force_hold, track_enable, manual_tune_value};
            `HSC_IDX_STATUS:     next_rdata = {12'h000, track_code, 1'b0, absent_now, ref_active,
                                               state, pump_float, holdover_active};
            default:             next_rdata = 32'h00000000;
        endcase
    end

    // APB answer: no wait state, ready pulses for one cycle.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= next_rdata;
            pready  <= 1'b1;
            pslverr <= ~idx_ok || (next_rdata == 32'h00000000 && reg_idx != `HSC_IDX_RATE_TRIP &&
                       reg_idx != `HSC_IDX_RATE_COUNT && reg_idx != `HSC_IDX_SWITCH_CFG &&
                       reg_idx != `HSC_IDX_LOW_TRIP && reg_idx != `HSC_IDX_EXIT_COUNT &&
                       reg_idx != `HSC_IDX_TUNE_CTRL && reg_idx != `HSC_IDX_STATUS);
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== hsc_regs.vh
// Purpose: Register offsets, field positions, reset values and counts for holdover switch control.
// Assumes: APB with 32-bit data; printed offsets are not all multiples of four, so they are word indices.
// Notes:   Byte address of a register is four times its index.
`ifndef HSC_REGS_VH
`define HSC_REGS_VH

// Printed register indices.
`define HSC_IDX_RATE_TRIP    10'h14E
`define HSC_IDX_RATE_COUNT   10'h14F
`define HSC_IDX_SWITCH_CFG   10'h150
// Extra registers placed next to the printed ones.
`define HSC_IDX_LOW_TRIP     10'h151
`define HSC_IDX_EXIT_COUNT   10'h152
`define HSC_IDX_TUNE_CTRL    10'h153
`define HSC_IDX_STATUS       10'h154

// Reset values.
`define HSC_RST_RATE_TRIP    8'h00
`define HSC_RST_RATE_COUNT   8'h7F
`define HSC_RST_SWITCH_CFG   8'h00
`define HSC_RST_LOW_TRIP     6'h00
`define HSC_RST_EXIT_COUNT   14'h0002
`define HSC_RST_TRACK_CODE   10'h200
`define HSC_RST_MANUAL_TUNE  10'h200

// Fields of the switch configuration register.
`define HSC_CFG_FORCE_SEL    6
`define HSC_CFG_EXIT_MODE    5
`define HSC_CFG_LOCK_DROP    4
`define HSC_CFG_EXT_ABSENT   3
`define HSC_CFG_RAIL_DET     2
`define HSC_CFG_PUMP_FLOAT   1
`define HSC_CFG_HOLD_EN      0

// Fields of the tune control register.
`define HSC_TC_TRACK_EN      10
`define HSC_TC_FORCE_HOLD    11
`define HSC_TC_MAN_EN        12
`define HSC_TC_MAN_SEL_LSB   13

// Tracking multipliers, as log2 of 4, 64, 1024 and 16384.
`define HSC_MULT_SHIFT0      5'd2
`define HSC_MULT_SHIFT1      5'd6
`define HSC_MULT_SHIFT2      5'd10
`define HSC_MULT_SHIFT3      5'd14

// Switch event lasts this many clocks so the pump float is visible.
`define HSC_SWITCH_CYCLES    4'd8

`endif

// ===== hsc_sync_count.v
// Purpose: Loadable down counter that pulses and reloads when it is at one or zero.
// Assumes: Load has priority over counting.
// Notes:   Used for the tracking update rate.
`timescale 1ns/1ns
`default_nettype none
module hsc_sync_count #(
    parameter WIDTH = 22
) (
    // Clock and reset.
    input  wire             clk,
    input  wire             arst_n,
    // Control.
    input  wire             load,
    input  wire [WIDTH-1:0] load_value,
    input  wire             run,
    // Result.
    output reg              expired
);
    reg [WIDTH-1:0] count;

    // Counts down while running, reloads and pulses when it ends.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count   <= {WIDTH{1'b0}};
            expired <= 1'b0;
        end else if (load) begin
            count   <= load_value;
            expired <= 1'b0;
        end else if (run) begin
            if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                count   <= load_value;
                expired <= 1'b1;
            end else begin
                count   <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                expired <= 1'b0;
            end
        end else begin
            expired <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== hsc_monitor.sv
// Purpose: Concurrent checks on the holdover switch control ports.
// Assumes: One clock domain; an APB slave answers one cycle after the setup cycle.
// Notes:   Bound to every hsc_holdover_switch instance; sees ports only.
`timescale 1ns/1ns
`default_nettype none
`include "hsc_regs.vh"
module hsc_monitor #(
    parameter CODE_W = 10
) (
    // Clock and reset.
    input wire logic              clk,
    input wire logic              arst_n,
    // APB.
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Loop and clock path.
    input wire logic              loop_locked,
    input wire logic              pd_clk_valid,
    input wire logic [CODE_W-1:0] tune_code,
    input wire logic [2:0]        int_signal_absent,
    input wire logic              ref_select_pin_zero,
    input wire logic              ref_select_pin_one,
    input wire logic              status_pin_one,
    input wire logic [1:0]        ref_active,
    input wire logic              holdover_active,
    input wire logic              pump_float,
    input wire logic              dyn_delay_allow,
    input wire logic [CODE_W-1:0] tune_dac
);
    // Decode of the setup cycle, mapped words and a completed configuration write.
    wire logic setup  = psel && !penable;
    wire logic mapped = (paddr[1:0] == 2'h0) && (paddr[11:2] >= `HSC_IDX_RATE_TRIP) && (paddr[11:2] <= `HSC_IDX_STATUS);
    wire logic cfg_wr = psel && penable && pwrite && pready && (paddr == {`HSC_IDX_SWITCH_CFG, 2'h0});

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_ready_after_setup: assert property (setup |=> pready) else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready stood too long");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
    a_error_unmapped: assert property (setup && !mapped |=> pslverr && pready) else $error("unmapped not refused");
    a_no_error_mapped: assert property (setup && mapped |=> !pslverr) else $error("mapped word refused");
    a_cfg_reserved_zero: assert property (pready && !pwrite && paddr == {`HSC_IDX_SWITCH_CFG, 2'h0}
        |-> prdata[31:7] == 25'h0) else $error("reserved bits read nonzero");
    a_override_stops_delay: assert property (cfg_wr && pwdata[6] |-> ##[1:2] !dyn_delay_allow)
        else $error("delay adjust left on");
    a_override_frees_delay: assert property (cfg_wr && !pwdata[6] |-> ##[1:2] dyn_delay_allow)
        else $error("delay adjust left off");
    a_ref_in_range: assert property (ref_active != 2'h3) else $error("reference choice out of range");
    a_float_window: assert property ($rose(pump_float) |-> pump_float [*8]) else $error("pump float cut short");

    // Main scenarios reached.
    c_override: cover property (cfg_wr && pwdata[6]);
    c_hold_entry: cover property ($rose(holdover_active));
    c_float: cover property ($rose(pump_float));
endmodule
bind hsc_holdover_switch hsc_monitor #(.CODE_W(CODE_W)) u_monitor (.*);
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for holdover switch control.
// Assumes: APB master waits for pready; each scenario starts from a fresh reset.
// Notes:   Tracking periods use small counter values to keep the run short.
`timescale 1ns/1ns
`default_nettype none
`include "hsc_regs.vh"
module tb;
    localparam logic [11:0] A_RT = {`HSC_IDX_RATE_TRIP, 2'h0};
    localparam logic [11:0] A_CNT = {`HSC_IDX_RATE_COUNT, 2'h0};
    localparam logic [11:0] A_CFG = {`HSC_IDX_SWITCH_CFG, 2'h0};
    localparam logic [11:0] A_TC = {`HSC_IDX_TUNE_CTRL, 2'h0};
    localparam logic [11:0] A_LO = {`HSC_IDX_LOW_TRIP, 2'h0};
    localparam logic [11:0] A_ST = {`HSC_IDX_STATUS, 2'h0};
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, loop_locked = 1, pd_clk_valid = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, er, pin0 = 0, pin1 = 0, spin = 0, holdover_active, pump_float, dyn_delay_allow;
    logic [9:0] tune_code = 10'h200, tune_dac;
    logic [2:0] int_absent = 0;
    logic [1:0] ref_active;
    int bad_count = 0, num_checks = 0, cycles = 0;

    hsc_holdover_switch u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .loop_locked(loop_locked), .pd_clk_valid(pd_clk_valid), .tune_code(tune_code),
        .int_signal_absent(int_absent), .ref_select_pin_zero(pin0), .ref_select_pin_one(pin1),
        .status_pin_one(spin), .ref_active(ref_active), .holdover_active(holdover_active),
        .pump_float(pump_float), .dyn_delay_allow(dyn_delay_allow), .tune_dac(tune_dac));

    // Clock and a cycle ceiling that cuts a hang short.
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask

    // One APB transfer; the request stands until pready is seen.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(rd, e);
    endtask

    task automatic rst();
        arst_n <= 0;
        repeat (3) @(posedge clk);
        arst_n <= 1;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wait_hold(input logic v);
        repeat (40) begin
            @(negedge clk);
            if (holdover_active === v) break;
        end
        chk(32'(holdover_active), 32'(v));
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge clk) pd_clk_valid <= 1;
            @(posedge clk) pd_clk_valid <= 0;
        end
        settle(2);
    endtask

    // Reset values, reserved bit, refused word.
    task automatic t_regs();
        rdc(A_RT, 32'h00);
        rdc(A_CNT, 32'h7F);
        rdc(A_CFG, 32'h00);
        wr(A_CFG, 32'hFF);
        rdc(A_CFG, 32'h7F);
        apb(0, 12'h600, 0);
        chk(32'(er), 32'h1);
    endtask

    // Override with each manual choice stops delay adjustment.
    task automatic t_override();
        rst();
        for (int k = 0; k < 3; k++) begin
            wr(A_TC, 32'h1000 | (k << 13));
            wr(A_CFG, 32'h40);
            settle(1);
            chk(32'(ref_active), k);
            chk(32'(dyn_delay_allow), 32'h0);
        end
        wr(A_CFG, 32'h00);
        settle(1);
        chk(32'(dyn_delay_allow), 32'h1);
    endtask

    // Forced holdover on the manual value, pump float, then counted exit.
    task automatic t_force();
        rst();
        wr(A_TC, 32'h1955);
        wr(A_CFG, 32'h03);
        wait_hold(1);
        chk(32'(tune_dac), 32'h155);
        chk(32'(pump_float), 32'h1);
        wr(A_TC, 32'h1155);
        pulse(2);
        chk(32'(holdover_active), 32'h1);
        pulse(1);
        wait_hold(0);
        chk(32'(tune_dac), 32'(tune_code));
    endtask

    // Lock drop counts only when enabled; exit waits for lock.
    task automatic t_lock();
        rst();
        wr(A_CFG, 32'h21);
        loop_locked <= 0;
        settle(6);
        chk(32'(holdover_active), 32'h0);
        @(posedge clk) loop_locked <= 1;
        wr(A_CFG, 32'h31);
        loop_locked <= 0;
        wait_hold(1);
        chk(32'(tune_dac), 32'h200);
        pulse(4);
        chk(32'(holdover_active), 32'h1);
        @(posedge clk) loop_locked <= 1;
        settle(2);
        pulse(3);
        wait_hold(0);
    endtask

    // External pins replace internal detectors and map to references.
    task automatic t_ext();
        rst();
        wr(A_CFG, 32'h09);
        int_absent <= 3'b001;
        settle(6);
        chk(32'(holdover_active), 32'h0);
        @(posedge clk) spin <= 1;
        pin1 <= 1;
        apb(0, A_ST, 0);
        chk(32'(rd[8:6]), 32'h6);
        pin0 <= 1;
        wait_hold(1);
        chk(32'(ref_active), 32'h2);
        @(posedge clk) {pin0, pin1, spin, int_absent} <= 0;
    endtask

    // High and low rail trips at their thresholds, with no trip one step inside each.
    task automatic t_rail();
        rst();
        wr(A_RT, 32'h01);
        wr(A_LO, 32'h10);
        wr(A_CFG, 32'h05);
        tune_code <= 10'h3D0;
        settle(6);
        chk(32'(holdover_active), 32'h0);
        @(posedge clk) tune_code <= 10'h3E0;
        wait_hold(1);
        chk(32'(ref_active), 32'h1);
        chk(32'(pump_float), 32'h0);
        @(posedge clk) tune_code <= 10'h110;
        pulse(3);
        wait_hold(0);
        @(posedge clk) tune_code <= 10'h100;
        wait_hold(1);
        @(posedge clk) tune_code <= 10'h200;
    endtask

    // Tracking rate with each of the four multipliers.
    task automatic t_track();
        rst();
        rdc(A_ST, 32'h200 << 10);
        tune_code <= 10'h123;
        wr(A_CNT, 32'h02);
        wr(A_TC, 32'h600);
        settle(12);
        apb(0, A_ST, 0);
        chk(32'(rd[19:10]), 32'h123);
        wr(A_RT, 32'hC0);
        wr(A_CNT, 32'h01);
        tune_code <= 10'h0F0;
        settle(200);
        apb(0, A_ST, 0);
        chk(32'(rd[19:10]), 32'h123);
        settle(16400);
        apb(0, A_ST, 0);
        chk(32'(rd[19:10]), 32'h0F0);
        wr(A_RT, 32'h40);
        wr(A_CNT, 32'h01);
        tune_code <= 10'h0A0;
        settle(50);
        apb(0, A_ST, 0);
        chk(32'(rd[19:10]), 32'h0F0);
        settle(20);
        apb(0, A_ST, 0);
        chk(32'(rd[19:10]), 32'h0A0);
        wr(A_RT, 32'h80);
        @(posedge clk) tune_code <= 10'h055;
        settle(900);
        apb(0, A_ST, 0);
        chk(32'(rd[19:10]), 32'h0A0);
        settle(200);
        apb(0, A_ST, 0);
        chk(32'(rd[19:10]), 32'h055);
    endtask

    initial begin
        rst();
        t_regs();
        t_override();
        t_force();
        t_lock();
        t_ext();
        t_rail();
        t_track();
        test_done();
    end
endmodule
`default_nettype wire
